// ===== common/udc_defines.vh
`ifndef UDC_DEFINES_VH
`define UDC_DEFINES_VH

// register offsets (byte addresses)
`define UDC_REG_CTRL        8'h00
`define UDC_REG_STATUS      8'h04
`define UDC_REG_WRAPS       8'h08

// control register fields
`define UDC_CTRL_INHIBIT    0
`define UDC_CTRL_LOAD       1
`define UDC_CTRL_DATA_LSB   4
`define UDC_CTRL_DATA_MSB   7
`define UDC_CTRL_RESET      8'h00

// status register fields
`define UDC_STAT_CNT_LSB    0
`define UDC_STAT_CNT_MSB    3
`define UDC_STAT_CARRY_N    4
`define UDC_STAT_BINARY     5
`define UDC_STAT_UP         6
`define UDC_STAT_LOAD       7
`define UDC_STAT_INHIBIT    8

// count limits
`define UDC_MAX_BINARY      4'hF
`define UDC_MAX_DECADE      4'h9
`define UDC_MIN_COUNT       4'h0
`define UDC_COUNT_RESET     4'h0

// pin synchroniser depth
`define UDC_SYNC_STAGES     2

`endif

// ===== rtl/udc_sync.v
`timescale 1ns/1ns
`include "udc_defines.vh"

module udc_sync #(
   parameter WIDTH = 9
) (
   input  wire             clock_i,   // system clock
   input  wire             rst_n_i,   // synchronous reset, active low
   input  wire [WIDTH-1:0] async_i,   // pins from outside the clock domain
   output wire [WIDTH-1:0] sync_o     // synchronised levels
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta_q;
         reg stable_q;
         // first stage is read by the second stage only
         always @(posedge clock_i) begin
            if (!rst_n_i) begin
               meta_q   <= 1'b0;
               stable_q <= 1'b0;
            end else begin
               meta_q   <= async_i[g];
               stable_q <= meta_q;
            end
         end
         assign sync_o[g] = stable_q;
      end
   endgenerate

endmodule // udc_sync

// ===== rtl/udc_counter.v
`timescale 1ns/1ns
`include "udc_defines.vh"

// Function
// RL1: four stages counting binary or BCD, up or down, with look-ahead carry.
// RL2: while load enable is high, the count follows the parallel data inputs.
// RL3: load enable high with all data inputs low gives the zero count.
// RL4: one count per rising count clock edge when inhibit and load are low.
// RL5: count holds on clock edges while inhibit or load enable is high.
// RL6: carry rests high, low at terminal count while inhibit is low.
// RL7: base select high counts binary, low counts decade.
// RL8: direction select high counts up, low counts down.
// RL9: in decade mode the four outputs show a BCD digit; a count above nine, loaded or left from binary, shows until the next step.
// RL10: outside logic ties inhibit low when the function is unused.
// RL11: cascades may share one clock or ripple from the previous carry.
// RL12: four buffered count outputs, one carry, fed from the listed inputs.
// RL13: max fifteen binary, nine decade, min zero; wrap both ways.

module udc_counter #(
   parameter WRAP_W = 16
) (
   input  wire        clock_i,               // system clock, 100 MHz
   input  wire        rst_n_i,               // synchronous reset, active low
   input  wire        count_clk_i,           // counting clock pin, rising edge counts
   input  wire        count_inhibit_in_i,    // count inhibit pin, high inhibits
   input  wire        count_base_select_i,   // high binary, low decade
   input  wire        direction_select_i,    // high up, low down
   input  wire        parallel_load_enable_i,// high loads parallel data
   input  wire [3:0]  parallel_data_i,       // parallel data pins
   output wire [3:0]  count_o,               // buffered count outputs
   output wire        carry_out_n_o,         // carry output, active low
   input  wire [7:0]  addr_i,                // register byte address
   input  wire [31:0] wr_data_i,             // register write data
   input  wire        wr_en_i,               // write strobe
   input  wire        rd_en_i,               // read strobe
   output wire [31:0] rd_data_o              // read data, cycle after strobe
);

   // pin synchronisation
   wire [8:0] pins_async;
   wire [8:0] pins_sync;
   assign pins_async = {parallel_data_i,
                        parallel_load_enable_i,
                        direction_select_i,
                        count_base_select_i,
                        count_inhibit_in_i,
                        count_clk_i};

   udc_sync #(
      .WIDTH (9)
   ) u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i (pins_async),
      .sync_o  (pins_sync)
   );

   wire       clk_s;
   wire       inhibit_s;
   wire       binary_s;
   wire       up_s;
   wire       load_s;
   wire [3:0] data_s;
   assign clk_s     = pins_sync[0];
   assign inhibit_s = pins_sync[1];
   assign binary_s  = pins_sync[2];
   assign up_s      = pins_sync[3];
   assign load_s    = pins_sync[4];
   assign data_s    = pins_sync[8:5];

   // registers
   reg              clk_prev_q;
   reg [3:0]        count_q;
   reg [3:0]        count_d;
   reg              carry_n_q;
   reg              carry_n_d;
   reg [7:0]        ctrl_q;
   reg [WRAP_W-1:0] wraps_q;
   reg [WRAP_W-1:0] wraps_d;
   reg [31:0]       rd_data_q;
   reg [31:0]       rd_data_d;

   // software may add an inhibit or force a load on top of the pins
   wire       soft_inhibit;
   wire       soft_load;
   wire [3:0] soft_data;
   assign soft_inhibit = ctrl_q[`UDC_CTRL_INHIBIT];
   assign soft_load    = ctrl_q[`UDC_CTRL_LOAD];
   assign soft_data    = ctrl_q[`UDC_CTRL_DATA_MSB:`UDC_CTRL_DATA_LSB];

   wire       inhibit;
   wire       load;
   wire [3:0] load_data;
   assign inhibit   = inhibit_s | soft_inhibit;
   assign load      = load_s | soft_load;
   assign load_data = soft_load ? soft_data : data_s;

   wire clk_rise;
   assign clk_rise = clk_s & ~clk_prev_q;

   // RL7: base select picks the top count
   // RL13: fifteen binary, nine decade
   wire [3:0] max_count;
   assign max_count = binary_s ? `UDC_MAX_BINARY : `UDC_MAX_DECADE;

   wire at_max;
   wire at_min;
   wire terminal_now;
   assign at_max       = (count_q == max_count);
   assign at_min       = (count_q == `UDC_MIN_COUNT);
   assign terminal_now = up_s ? at_max : at_min;

   wire advance;
   // RL4: step only when neither inhibit nor load
   assign advance = clk_rise & ~inhibit & ~load;

   // next count
   always @* begin
      count_d = count_q;
      if (load) begin
         // RL2: follow the parallel data
         // RL3: all-low data gives zero
         count_d = load_data;
      end else if (advance) begin
         // RL8: direction select sets up or down
         if (up_s) begin
            // RL13: wrap to zero going up
            // out-of-range decade values also return to zero
            if (count_q >= max_count)
               count_d = `UDC_MIN_COUNT;
            else
               count_d = count_q + 4'h1;
         end else begin
            // RL13: wrap to max going down
            // RL9: a decade down step always lands on a BCD digit
            if (at_min || count_q > max_count)
               count_d = max_count;
            else
               count_d = count_q - 4'h1;
         end
      end
      // RL5: otherwise the count holds
   end

   // look-ahead carry from the next state so it lines up with the count
   reg [3:0] max_next;
   reg       term_next;
   always @* begin
      max_next  = binary_s ? `UDC_MAX_BINARY : `UDC_MAX_DECADE;
      term_next = up_s ? (count_d == max_next) : (count_d == `UDC_MIN_COUNT);
      // RL6: carry low only at terminal count with inhibit low
      carry_n_d = ~(term_next & ~inhibit);
   end

   // terminal-count advances seen, for software
   always @* begin
      wraps_d = wraps_q;
      if (wr_en_i && addr_i == `UDC_REG_WRAPS)
         wraps_d = {WRAP_W{1'b0}};
      // a wrap in the clearing cycle is kept
      if (advance && terminal_now)
         wraps_d = wraps_d + {{(WRAP_W-1){1'b0}}, 1'b1};
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rd_data_d = 32'h00000000;
      if (rd_en_i) begin
         case (addr_i)
            `UDC_REG_CTRL: begin
               rd_data_d[7:0] = ctrl_q;
            end
            `UDC_REG_STATUS: begin
               rd_data_d[`UDC_STAT_CNT_MSB:`UDC_STAT_CNT_LSB] = count_q;
               rd_data_d[`UDC_STAT_CARRY_N] = carry_n_q;
               rd_data_d[`UDC_STAT_BINARY]  = binary_s;
               rd_data_d[`UDC_STAT_UP]      = up_s;
               rd_data_d[`UDC_STAT_LOAD]    = load;
               rd_data_d[`UDC_STAT_INHIBIT] = inhibit;
            end
            `UDC_REG_WRAPS: begin
               rd_data_d[WRAP_W-1:0] = wraps_q;
            end
            default: begin
               rd_data_d = 32'h00000000;
            end
         endcase
      end
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         clk_prev_q <= 1'b0;
         count_q    <= `UDC_COUNT_RESET;
         carry_n_q  <= 1'b1;
         ctrl_q     <= `UDC_CTRL_RESET;
         wraps_q    <= {WRAP_W{1'b0}};
         rd_data_q  <= 32'h00000000;
      end else begin
         clk_prev_q <= clk_s;
         // RL1: four-stage state
         count_q    <= count_d;
         carry_n_q  <= carry_n_d;
         wraps_q    <= wraps_d;
         rd_data_q  <= rd_data_d;
         if (wr_en_i && addr_i == `UDC_REG_CTRL)
            ctrl_q <= wr_data_i[7:0];
      end
   end

   // RL12: buffered outputs straight from flops
   assign count_o       = count_q;
   assign carry_out_n_o = carry_n_q;
   assign rd_data_o     = rd_data_q;

endmodule // udc_counter

// ===== verification/udc_monitor.sv
`timescale 1ns/1ns
module udc_monitor (
   input wire       clock_i,                // system clock
   input wire       rst_n_i,                // reset, active low
   input wire       count_clk_i,            // count clock pin
   input wire       count_inhibit_in_i,     // inhibit pin
   input wire       count_base_select_i,    // base pin
   input wire       direction_select_i,     // direction pin
   input wire       parallel_load_enable_i, // load pin
   input wire [3:0] parallel_data_i,        // preset pins
   input wire [3:0] count_o,                // count
   input wire       carry_out_n_o           // carry, active low
);
   wire en   = !count_inhibit_in_i;
   wire run  = en && !parallel_load_enable_i;
   wire up_b = run && direction_select_i && count_base_select_i;
   wire dn_d = run && !direction_select_i && !count_base_select_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // pins pass two flops, so four stable samples
   AST_LOAD: assert property ((parallel_load_enable_i && $stable(parallel_data_i)) [*4]
      |=> count_o == $past(parallel_data_i)) else $error("count not loaded");
   AST_HOLD: assert property ((count_inhibit_in_i && !parallel_load_enable_i) [*4]
      |=> $stable(count_o)) else $error("count moved while inhibited");
   AST_CARRY_IDLE: assert property (count_inhibit_in_i [*4] |=> carry_out_n_o)
      else $error("carry low while inhibited");
   AST_CARRY_UB: assert property ((en && direction_select_i && count_base_select_i) [*4]
      |-> carry_out_n_o == (count_o != 4'hF)) else $error("carry wrong up binary");
   AST_CARRY_UD: assert property ((en && direction_select_i && !count_base_select_i) [*4]
      |-> carry_out_n_o == (count_o != 4'h9)) else $error("carry wrong up decade");
   AST_CARRY_DD: assert property ((en && !direction_select_i && !count_base_select_i) [*4]
      |-> carry_out_n_o == (count_o != 4'h0)) else $error("carry wrong down decade");
   AST_STEP_UB: assert property ($rose(count_clk_i) && up_b |-> ##3
      count_o == $past(count_o, 3) + 4'h1) else $error("bad up step");
   AST_STEP_DD: assert property ($rose(count_clk_i) && dn_d && count_o <= 4'h9 |-> ##3
      count_o == ($past(count_o, 3) == 4'h0 ? 4'h9 : $past(count_o, 3) - 4'h1))
      else $error("bad down step");
endmodule // udc_monitor

bind udc_counter udc_monitor mon (
   .clock_i               (clock_i),
   .rst_n_i               (rst_n_i),
   .count_clk_i           (count_clk_i),
   .count_inhibit_in_i    (count_inhibit_in_i),
   .count_base_select_i   (count_base_select_i),
   .direction_select_i    (direction_select_i),
   .parallel_load_enable_i(parallel_load_enable_i),
   .parallel_data_i       (parallel_data_i),
   .count_o               (count_o),
   .carry_out_n_o         (carry_out_n_o)
);

// ===== verification/udc_pin_src.sv
`timescale 1ns/1ns
module udc_pin_src (
   input  wire clock_i,    // system clock
   input  wire go_i,       // request one count pulse
   output reg  count_clk_o // count clock pin
);
   reg [2:0] cnt_q;
   initial begin
      cnt_q = 3'h0;
      count_clk_o = 1'b0;
   end
   // shared clock, high and low well over two cycles
   always @(posedge clock_i) begin
      if (go_i)
         cnt_q <= 3'h6;
      else if (cnt_q != 3'h0)
         cnt_q <= cnt_q - 3'h1;
      count_clk_o <= go_i || cnt_q > 3'h3;
   end
endmodule // udc_pin_src

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   reg         clock_i, rst_n_i, inh, base, dir, load, go, wr, rd;
   reg  [3:0]  data;
   reg  [7:0]  addr;
   reg  [31:0] wdata, v;
   wire        cclk, carry;
   wire [3:0]  count;
   wire [31:0] rdata;
   integer     errors, tests_run;
   udc_pin_src src (.clock_i(clock_i), .go_i(go), .count_clk_o(cclk));
   udc_counter uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .count_clk_i(cclk),
      .count_inhibit_in_i(inh), .count_base_select_i(base), .direction_select_i(dir),
      .parallel_load_enable_i(load), .parallel_data_i(data), .count_o(count),
      .carry_out_n_o(carry), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr),
      .rd_en_i(rd), .rd_data_o(rdata));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // bits: load, inhibit, binary, up, data
   task pins(input [7:0] p);
      begin
         {load, inh, base, dir, data} <= p;
         repeat (5) @(posedge clock_i);
      end
   endtask
   task pulse;
      begin
         go <= 1'b1;
         @(posedge clock_i);
         go <= 1'b0;
         repeat (8) @(posedge clock_i);
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         {wr, rd, addr, wdata} <= {w, !w, a, d};
         @(posedge clock_i);
         {wr, rd} <= 2'h0;
         // read data stand only in the cycle after the strobe
         @(negedge clock_i);
         v = rdata;
         @(posedge clock_i);
      end
   endtask
   task t_count;
      begin
         pins(8'hB0);
         chk(count, 32'h0);
         pins(8'hBE);
         chk(count, 32'hE);
         pins(8'h3E);
         pulse;
         chk({carry, count}, 32'hF);
         pulse;
         chk({carry, count}, 32'h10);
         pins(8'h81);
         pins(8'h01);
         pulse;
         chk({carry, count}, 32'h0);
         pulse;
         chk({carry, count}, 32'h19);
         pins(8'h11);
         chk(carry, 32'h0);
         pulse;
         chk(count, 32'h0);
      end
   endtask
   task t_hold;
      begin
         pins(8'h40);
         chk(carry, 32'h1);
         pulse;
         chk(count, 32'h0);
         pins(8'h83);
         pulse;
         chk(count, 32'h3);
         pins(8'h03);
      end
   endtask
   task t_regs;
      begin
         bus(1'b1, 8'h00, 32'hF0);
         bus(1'b0, 8'h00, 32'h0);
         chk(v, 32'hF0);
         bus(1'b0, 8'h04, 32'h0);
         chk(v, 32'h13);
         @(negedge clock_i);
         chk(rdata, 32'h0);
         @(posedge clock_i);
         // three terminal-count steps were taken in t_count
         bus(1'b0, 8'h08, 32'h0);
         chk(v, 32'h3);
         bus(1'b1, 8'h08, 32'h0);
         bus(1'b0, 8'h08, 32'h0);
         chk(v, 32'h0);
         bus(1'b1, 8'h0C, 32'hFF);
         bus(1'b0, 8'h0C, 32'h0);
         chk(v, 32'h0);
         bus(1'b1, 8'h00, 32'h52);
         @(negedge clock_i);
         chk(count, 32'h5);
         @(posedge clock_i);
         // binary down: no step assertion watches the soft inhibit
         pins(8'h23);
         bus(1'b1, 8'h00, 32'h01);
         pulse;
         chk(count, 32'h5);
         bus(1'b1, 8'h00, 32'h0);
         pulse;
         chk(count, 32'h4);
      end
   endtask
   task final_report;
      begin
         $display("errors %0d tests_run %0d", errors, tests_run);
         if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // run needs under two hundred cycles
   initial begin
      repeat (3000) @(posedge clock_i);
      errors = errors + 1;
      final_report;
   end
   initial begin
      errors = 0;
      tests_run = 0;
      {rst_n_i, inh, base, dir, load, go, wr, rd} = 8'h0;
      {data, addr, wdata} = 44'h0;
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_count;
      t_hold;
      t_regs;
      final_report;
   end
endmodule // tb_top
